// ---- hdl/mag_pkg.sv ----
// package: register map, instruction fields and states of the address generator
package mag_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_INSTR    = 8'h04;
	localparam logic [7:0] REG_BASE     = 8'h08;
	localparam logic [7:0] REG_IADDR    = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;
	localparam logic [7:0] REG_CUR_ADDR = 8'h14;
	localparam logic [7:0] REG_NEW_BASE = 8'h18;

	// field positions
	localparam int CMD_START_BIT = 0;
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_DONE_BIT  = 1;
	localparam int STS_STACK_LSB = 2;
	localparam int STS_WORDS_LSB = 8;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// address arithmetic
	localparam logic [31:0] PC_AHEAD  = 32'h0000_0008;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [4:0]  MAX_WORDS = 5'h10;

	// instruction word as software loads it
	typedef struct packed {
		logic        cond_pass;
		logic        base_is_pc;
		logic        copro;
		logic        size_n;
		logic        wb;
		logic        up;
		logic        pre;
		logic        load;
		logic [7:0]  offset8;
		logic [15:0] reglist;
	} mag_instr_s;

	// block addressing modes, {pre, up}
	typedef enum logic [1:0] {
		MODE_DECR_AFTER  = 2'b00,
		MODE_INCR_AFTER  = 2'b01,
		MODE_DECR_BEFORE = 2'b10,
		MODE_INCR_BEFORE = 2'b11
	} mag_mode_e;

	// stack views of a block transfer
	typedef enum logic [1:0] {
		FULL_DESCENDING_STACK  = 2'b00,
		EMPTY_DESCENDING_STACK = 2'b01,
		FULL_ASCENDING_STACK   = 2'b10,
		EMPTY_ASCENDING_STACK  = 2'b11
	} mag_stack_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WALK = 2'b01
	} mag_state_e;

endpackage

// ---- hdl/mag_addr_gen.sv ----
// block and coprocessor load/store address generator with apb control
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module mag_addr_gen #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// address stream to memory
	output logic                   mem_addr_valid,
	input  wire logic              mem_accept,
	output logic [31:0]            mem_addr,
	output logic                   mem_load,
	// coprocessor side
	output logic                   cp_size,
	input  wire logic              cp_finished,
	// base writeback
	output logic                   wb_valid,
	output logic [31:0]            wb_data
);

	generate
		if (ADDR_W < 5)
		begin : g_chk
			$error("ADDR_W too small for register map");
		end
	endgenerate

	mag_pkg::mag_state_e state;
	mag_pkg::mag_instr_s instr;
	logic [31:0]         base_reg;
	logic [31:0]         iaddr;
	logic                done;
	logic [4:0]          words;
	logic [4:0]          blk_cnt;
	logic [31:0]         new_base;

	logic                acc;
	logic                start_fire;
	logic                last_word;
	logic [31:0]         base_val;
	logic [4:0]          cnt_now;
	logic [31:0]         span;
	logic [31:0]         offs;
	logic [31:0]         co_sum;
	logic [31:0]         next_first;
	logic [31:0]         next_base;
	logic                next_wb;

	// number of listed registers
	function automatic logic [4:0] pop16(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, v[i]};
		return n;
	endfunction

	// first block address per mode
	function automatic logic [31:0] blk_start(input mag_pkg::mag_mode_e m,
		input logic [31:0] b, input logic [31:0] s);
		logic [31:0] r;
		r = b;
		case (m)
			mag_pkg::MODE_INCR_AFTER:  r = b;
			mag_pkg::MODE_INCR_BEFORE: r = b + mag_pkg::WORD_STEP;
			mag_pkg::MODE_DECR_AFTER:  r = b - s + mag_pkg::WORD_STEP;
			mag_pkg::MODE_DECR_BEFORE: r = b - s;
			default:                   r = b;
		endcase
		return r;
	endfunction

	// stack view of a block transfer
	function automatic mag_pkg::mag_stack_e stack_of(input logic ld, input mag_pkg::mag_mode_e m);
		mag_pkg::mag_stack_e s;
		s = mag_pkg::FULL_DESCENDING_STACK;
		case (m)
			mag_pkg::MODE_INCR_AFTER:
				s = ld ? mag_pkg::FULL_DESCENDING_STACK : mag_pkg::EMPTY_ASCENDING_STACK;
			mag_pkg::MODE_INCR_BEFORE:
				s = ld ? mag_pkg::EMPTY_DESCENDING_STACK : mag_pkg::FULL_ASCENDING_STACK;
			mag_pkg::MODE_DECR_AFTER:
				s = ld ? mag_pkg::FULL_ASCENDING_STACK : mag_pkg::EMPTY_DESCENDING_STACK;
			mag_pkg::MODE_DECR_BEFORE:
				s = ld ? mag_pkg::EMPTY_ASCENDING_STACK : mag_pkg::FULL_DESCENDING_STACK;
			default:
				s = mag_pkg::FULL_DESCENDING_STACK;
		endcase
		return s;
	endfunction

	mag_pkg::mag_mode_e  mode;
	mag_pkg::mag_stack_e stack_kind;

	// apb decode
	assign acc        = psel && penable;
	assign pready     = 1'b1;
	assign start_fire = acc && pwrite && (paddr == ADDR_W'(mag_pkg::REG_CMD))
		&& pwdata[mag_pkg::CMD_START_BIT] && (state == mag_pkg::ST_IDLE);

	// address arithmetic for the instruction being started
	always_comb
	begin
		mode       = mag_pkg::mag_mode_e'({instr.pre, instr.up});
		stack_kind = stack_of(instr.load, mode);
		base_val   = instr.base_is_pc ? iaddr + mag_pkg::PC_AHEAD : base_reg;
		cnt_now    = pop16(instr.reglist);
		span       = {25'h0, cnt_now, 2'b00};
		offs       = {22'h0, instr.offset8, 2'b00};
		co_sum     = instr.up ? base_val + offs : base_val - offs;
		if (instr.copro)
		begin
			next_first = instr.pre ? co_sum : base_val;
			next_base  = co_sum;
			next_wb    = instr.wb;
		end
		else
		begin
			next_first = blk_start(mode, base_val, span);
			next_base  = instr.up ? base_val + span : base_val - span;
			next_wb    = instr.wb;
		end
	end

	// end of the walk
	assign last_word = instr.copro ? (cp_finished || words == mag_pkg::MAX_WORDS - 5'h1)
		: (words == blk_cnt - 5'h1);

	// instruction and operand registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr    <= mag_pkg::mag_instr_s'(mag_pkg::RST_WORD);
			base_reg <= mag_pkg::RST_WORD;
			iaddr    <= mag_pkg::RST_WORD;
		end
		else if (acc && pwrite && state == mag_pkg::ST_IDLE)
		begin
			if (paddr == ADDR_W'(mag_pkg::REG_INSTR))
				instr <= mag_pkg::mag_instr_s'(pwdata);
			else if (paddr == ADDR_W'(mag_pkg::REG_BASE))
				base_reg <= pwdata;
			else if (paddr == ADDR_W'(mag_pkg::REG_IADDR))
				iaddr <= pwdata;
		end
	end

	// walk state machine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state   <= mag_pkg::ST_IDLE;
			words   <= 5'h0;
			blk_cnt <= 5'h0;
		end
		else
		begin
			case (state)
				mag_pkg::ST_IDLE:
					if (start_fire)
					begin
						words   <= 5'h0;
						blk_cnt <= cnt_now;
						if (instr.cond_pass && (instr.copro || cnt_now != 5'h0))
							state <= mag_pkg::ST_WALK;
					end
				mag_pkg::ST_WALK:
					if (mem_accept)
					begin
						words <= words + 5'h1;
						if (last_word)
							state <= mag_pkg::ST_IDLE;
					end
				default:
					state <= mag_pkg::ST_IDLE;
			endcase
		end
	end

	assign mem_addr_valid = (state == mag_pkg::ST_WALK);

	// address output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_addr <= mag_pkg::RST_WORD;
			mem_load <= 1'b0;
			cp_size  <= 1'b0;
		end
		else if (start_fire && instr.cond_pass)
		begin
			mem_addr <= next_first;
			mem_load <= instr.load;
			cp_size  <= instr.size_n;
		end
		else if (mem_addr_valid && mem_accept && !last_word)
			mem_addr <= mem_addr + mag_pkg::WORD_STEP;
	end

	// base writeback
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wb_valid <= 1'b0;
			wb_data  <= mag_pkg::RST_WORD;
			new_base <= mag_pkg::RST_WORD;
		end
		else
		begin
			wb_valid <= start_fire && instr.cond_pass && next_wb;
			if (start_fire && instr.cond_pass && next_wb)
			begin
				wb_data  <= next_base;
				new_base <= next_base;
			end
		end
	end

	// completion flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done <= 1'b0;
		else if (state == mag_pkg::ST_WALK && mem_accept && last_word)
			done <= 1'b1;
		else if (start_fire)
			done <= !(instr.cond_pass && (instr.copro || cnt_now != 5'h0));
	end

	// read mux
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= mag_pkg::RST_WORD;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pslverr <= 1'b0;
			prdata  <= mag_pkg::RST_WORD;
			if (paddr == ADDR_W'(mag_pkg::REG_CMD))
				prdata <= mag_pkg::RST_WORD;
			else if (paddr == ADDR_W'(mag_pkg::REG_INSTR))
				prdata <= instr;
			else if (paddr == ADDR_W'(mag_pkg::REG_BASE))
				prdata <= base_reg;
			else if (paddr == ADDR_W'(mag_pkg::REG_IADDR))
				prdata <= iaddr;
			else if (paddr == ADDR_W'(mag_pkg::REG_STATUS))
			begin
				prdata[mag_pkg::STS_BUSY_BIT]                        <= mem_addr_valid;
				prdata[mag_pkg::STS_DONE_BIT]                        <= done;
				prdata[mag_pkg::STS_STACK_LSB+1:mag_pkg::STS_STACK_LSB] <= stack_kind;
				prdata[mag_pkg::STS_WORDS_LSB+4:mag_pkg::STS_WORDS_LSB] <= words;
			end
			else if (paddr == ADDR_W'(mag_pkg::REG_CUR_ADDR))
				prdata <= mem_addr;
			else if (paddr == ADDR_W'(mag_pkg::REG_NEW_BASE))
				prdata <= new_base;
			else
				pslverr <= 1'b1;
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_cond_fail_quiet: assert property (start_fire && !instr.cond_pass |=> !mem_addr_valid && !wb_valid)
		else $error("failed condition produced activity");
	a_addr_step_four: assert property (mem_addr_valid && mem_accept && !last_word
		|=> mem_addr_valid && mem_addr == $past(mem_addr) + 32'h4)
		else $error("address did not step by four");
	a_copro_pre_first: assert property (start_fire && instr.cond_pass && instr.copro && instr.pre
		|=> mem_addr == ($past(instr.up) ? $past(base_val) + {22'h0, $past(instr.offset8), 2'b00}
		: $past(base_val) - {22'h0, $past(instr.offset8), 2'b00}))
		else $error("pre-indexed first address wrong");
	a_copro_post_first: assert property (start_fire && instr.cond_pass && instr.copro && !instr.pre
		|=> mem_addr == $past(base_val))
		else $error("post-indexed first address wrong");
	a_copro_pre_wb: assert property (start_fire && instr.cond_pass && instr.copro && instr.pre && instr.wb
		|=> wb_valid && wb_data == mem_addr)
		else $error("pre-indexed writeback not first address");
	a_pc_base_ahead: assert property (start_fire && instr.base_is_pc && instr.cond_pass && instr.copro
		&& !instr.pre |=> mem_addr == $past(iaddr) + 32'h8)
		else $error("program counter base not plus eight");
	a_blk_incr_before: assert property (start_fire && instr.cond_pass && !instr.copro && instr.pre && instr.up
		&& instr.reglist != 16'h0 |=> mem_addr == $past(base_val) + 32'h4)
		else $error("incr_before start wrong");
	a_blk_wb_span: assert property (start_fire && instr.cond_pass && !instr.copro && instr.wb && instr.up
		|=> wb_data == $past(base_val) + {25'h0, $past(cnt_now), 2'b00})
		else $error("block writeback span wrong");
	a_blk_word_count: assert property (mem_addr_valid && mem_accept && !instr.copro && words == blk_cnt - 5'h1
		|=> !mem_addr_valid ##1 !mem_addr_valid)
		else $error("block walk length wrong");
	a_copro_finish: assert property (mem_addr_valid && mem_accept && instr.copro && cp_finished
		|=> !mem_addr_valid && done)
		else $error("walk ran past coprocessor finish");
	a_size_and_dir: assert property (start_fire && instr.cond_pass
		|=> cp_size == $past(instr.size_n) && mem_load == $past(instr.load))
		else $error("size or direction not passed");

	c_copro_multi: cover property (mem_addr_valid && instr.copro ##1 mem_accept [*3] ##1 !mem_addr_valid);
	c_blk_decr: cover property (start_fire && !instr.copro && !instr.up && instr.wb && instr.cond_pass);
	c_cond_fail: cover property (start_fire && !instr.cond_pass);
	c_bad_addr: cover property (psel && !penable ##1 pslverr);

endmodule

`default_nettype wire

// ---- dv/mag_cp_model.sv ----
// coprocessor and memory acceptor model for the address generator
`timescale 1ns/1ns
`default_nettype none

module mag_cp_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// bench control
	input  wire logic [4:0] words,
	input  wire logic       slow,
	// address handshake
	input  wire logic       mem_addr_valid,
	output logic            mem_accept,
	output logic            cp_finished
);
	logic [4:0] cnt;

	// accept every cycle, or every other cycle when stalling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 5'h00;
			mem_accept <= 1'b0;
		end
		else
		begin
			mem_accept <= slow ? !mem_accept : 1'b1;
			if (!mem_addr_valid)
				cnt <= 5'h00;
			else if (mem_accept)
				cnt <= cnt + 5'h01;
		end
	end

	// size bit is not looked at here
	// last word flagged, never past sixteen
	assign cp_finished = (cnt + 5'h01 == words) || (cnt == 5'h0F);
endmodule

`default_nettype wire

// ---- dv/multi_and_copro_addr_gen_tb_top.sv ----
// self-checking bench for the block and coprocessor address generator
`timescale 1ns/1ns
`default_nettype none

module multi_and_copro_addr_gen_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        mem_addr_valid;
	logic        mem_accept;
	logic [31:0] mem_addr;
	logic        mem_load;
	logic        cp_size;
	logic        cp_finished;
	logic        wb_valid;
	logic [31:0] wb_data;
	logic [4:0]  words = 5'h03;
	logic        slow = 1'b0;
	logic [31:0] addrs[$];
	logic [31:0] last_wb;
	logic        ld_seen;
	logic        sz_seen;
	logic        err_seen;
	logic [31:0] blk_first [4] = '{32'h0FF8, 32'h1000, 32'h0FF4, 32'h1004};
	logic [1:0]  stk [8]       = '{mag_pkg::EMPTY_DESCENDING_STACK, mag_pkg::EMPTY_ASCENDING_STACK,
		mag_pkg::FULL_DESCENDING_STACK, mag_pkg::FULL_ASCENDING_STACK, mag_pkg::FULL_ASCENDING_STACK,
		mag_pkg::FULL_DESCENDING_STACK, mag_pkg::EMPTY_ASCENDING_STACK, mag_pkg::EMPTY_DESCENDING_STACK};
	int          wb_cnt;
	int          err_total = 0;
	int          cmp_count = 0;
	int          tests = 0;

	always #4 pclk = ~pclk;

	mag_addr_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_addr_valid(mem_addr_valid), .mem_accept(mem_accept), .mem_addr(mem_addr), .mem_load(mem_load),
		.cp_size(cp_size), .cp_finished(cp_finished), .wb_valid(wb_valid), .wb_data(wb_data));

	mag_cp_model cp (.pclk(pclk), .presetn(presetn), .words(words), .slow(slow),
		.mem_addr_valid(mem_addr_valid), .mem_accept(mem_accept), .cp_finished(cp_finished));

	// record accepted addresses and writebacks
	always @(posedge pclk)
	begin
		if (mem_addr_valid === 1'b1 && mem_accept === 1'b1)
		begin
			addrs.push_back(mem_addr);
			ld_seen = mem_load;
			sz_seen = cp_size;
		end
		if (wb_valid === 1'b1)
		begin
			wb_cnt++;
			last_wb = wb_data;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic run(input logic [31:0] ins, input logic [31:0] base, input logic [31:0] ia,
		input logic [31:0] first, input int n, input int wbn, input logic [31:0] wbd);
		logic [31:0] r;
		int k;
		addrs.delete();
		wb_cnt = 0;
		apb(1'b1, mag_pkg::REG_INSTR, ins, r);
		apb(1'b1, mag_pkg::REG_BASE, base, r);
		apb(1'b1, mag_pkg::REG_IADDR, ia, r);
		apb(1'b1, mag_pkg::REG_CMD, 32'h0000_0001, r);
		r = 32'h0;
		for (k = 0; k < 100 && r[mag_pkg::STS_DONE_BIT] !== 1'b1; k++)
			apb(1'b0, mag_pkg::REG_STATUS, 32'h0, r);
		check({31'h0, r[mag_pkg::STS_DONE_BIT]}, 32'h1);
		check({27'h0, r[12:8]}, 32'(n));
		check(32'(addrs.size()), 32'(n));
		foreach (addrs[i])
			check(addrs[i], first + 32'(4 * i));
		check(32'(wb_cnt), 32'(wbn));
		if (wbn > 0)
			check(last_wb, wbd);
		if (n > 0)
			check({30'h0, ld_seen, sz_seen}, {30'h0, ins[24], ins[28]});
		tests++;
		$display("test %0d done", tests);
	endtask

	function automatic logic [31:0] mk(input logic [7:0] f, input logic [7:0] off, input logic [15:0] lst);
		return {f, off, lst};
	endfunction

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		wrap_up();
	end

	initial
	begin
		logic [31:0] r;
		logic [31:0] s;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int m = 0; m < 8; m++)
		begin
			slow <= m[2];
			s = m[0] ? 32'h100C : 32'h0FF4;
			run(mk({5'b10001, m[0], m[1], m[2]}, 8'h00, 16'h0111), 32'h1000, 32'h0, blk_first[m[1:0]], 3, 1, s);
			apb(1'b0, mag_pkg::REG_STATUS, 32'h0, r);
			check({30'h0, r[mag_pkg::STS_STACK_LSB+:2]}, {30'h0, stk[m]});
		end
		for (int m = 0; m < 4; m++)
		begin
			s = m[0] ? 32'h83FC : 32'h7C04;
			run(mk({3'b101, m[1], 1'b1, m[0], m[1], m[0]}, 8'hFF, 16'h0), 32'h8000, 32'h0,
				m[1] ? s : 32'h8000, 3, 1, s);
		end
		words <= 5'h02;
		run(mk(8'hEF, 8'h02, 16'h0), 32'h5A00, 32'h200, 32'h210, 2, 1, 32'h210);
		apb(1'b0, mag_pkg::REG_NEW_BASE, 32'h0, r);
		check(r, 32'h210);
		run(mk(8'hED, 8'h02, 16'h0), 32'h5A00, 32'h200, 32'h208, 2, 1, 32'h210);
		run(mk(8'hA6, 8'h01, 16'h0), 32'h40, 32'h0, 32'h44, 2, 0, 32'h0);
		words <= 5'h10;
		run(mk(8'hAD, 8'h00, 16'h0), 32'h100, 32'h0, 32'h100, 16, 1, 32'h100);
		apb(1'b0, mag_pkg::REG_CUR_ADDR, 32'h0, r);
		check(r, 32'h13C);
		run(mk(8'h09, 8'h00, 16'hFFFF), 32'h100, 32'h0, 32'h100, 0, 0, 32'h0);
		apb(1'b0, 8'h1C, 32'h0, r);
		check({31'h0, err_seen}, 32'h1);
		check(r, 32'h0);
		wrap_up();
	end
endmodule

`default_nettype wire
